//--- rtl/bus_area_config_register.sv
// Purpose: bus area configuration register with Wishbone slave
// Assumes: nrst is the power-on reset; manual reset never reaches here
// Notes: decoded controls come out registered for the bus controller
//
// Decided for this implementation: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module bus_area_config_register
  import bus_cfg_pkg::*;
#(
  parameter bit HAS_EXT_FEATURES = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic byte_order_pin,
  input wire logic bus_role_pin,
  input wire logic area0_type_pin,
  input wire logic bus_access_active,
  input wire logic bus_released,
  input wire logic standby_mode,
  output logic little_endian,
  output logic slave_mode,
  output logic area0_muxed_type,
  output logic data_pullup_en,
  output logic input_pullup_en,
  output logic output_pullup_en,
  output logic area1_byte_ctrl,
  output logic area4_byte_ctrl,
  output logic ext_request_accept,
  output logic partial_share_mode,
  output logic areas_muxed_select,
  output logic addr_strobe_drive_en,
  output logic [5:0] area0_burst_count,
  output logic area0_burst_rom
);
  // ----------------------------------------------------------------
  // pin capture
  // ----------------------------------------------------------------
  logic order_s, role_s, type_s;
  bit_sync u_sync_order (.clk(clk), .nrst(nrst), .pin(byte_order_pin),
    .sync(order_s));
  bit_sync u_sync_role (.clk(clk), .nrst(nrst), .pin(bus_role_pin),
    .sync(role_s));
  bit_sync u_sync_type (.clk(clk), .nrst(nrst), .pin(area0_type_pin),
    .sync(type_s));

  // pins are taken after the synchroniser has filled, then frozen
  typedef enum logic [3:0] {
    CAP_FILL1 = 4'b0001,
    CAP_FILL2 = 4'b0010,
    CAP_TAKE = 4'b0100,
    CAP_HOLD = 4'b1000
  } capture_state_t;
  capture_state_t cap_q, cap_d;
  logic order_q, role_q, type_q;
  always_comb begin
    case (cap_q)
      CAP_FILL1: cap_d = CAP_FILL2;
      CAP_FILL2: cap_d = CAP_TAKE;
      CAP_TAKE: cap_d = CAP_HOLD;
      CAP_HOLD: cap_d = CAP_HOLD;
      default: cap_d = CAP_FILL1;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cap_q <= CAP_FILL1;
    end else begin
      cap_q <= cap_d;
    end
  end

  // one sample only: later pin motion must not reach the stored modes
  wire take_pins = (cap_q == CAP_TAKE);
  wire order_d = order_s;
  wire role_d = ~role_s;
  wire type_d = ~type_s;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      order_q <= 1'b0;
    end else if (take_pins) begin
      order_q <= order_d;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      role_q <= 1'b0;
    end else if (take_pins) begin
      role_q <= role_d;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      type_q <= 1'b0;
    end else if (take_pins) begin
      type_q <= type_d;
    end
  end

  // ----------------------------------------------------------------
  // register store
  // ----------------------------------------------------------------
  logic [31:0] cfg_q, cfg_d;
  wire [31:0] wr_mask = WRITE_MASK_BASE
    & ~(HAS_EXT_FEATURES ? 32'h0000_0000 : DATA_PULLUP_MASK);
  wire [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire addr_hit = (wb_adr_i[31:2] == BUS_CONTROL_ONE_ADDR[31:2]);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire wr_hit = req && wb_we_i && addr_hit;
  wire [31:0] upd_mask = wr_mask & byte_mask;
  assign cfg_d = (cfg_q & ~upd_mask) | (wb_dat_i & upd_mask);

  // only power-on reset clears it; no manual reset or standby path
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cfg_q <= BUS_CONTROL_ONE_RESET;
    end else if (wr_hit) begin
      cfg_q <= cfg_d;
    end
  end

  // ----------------------------------------------------------------
  // read path and bus answer
  // ----------------------------------------------------------------
  logic [31:0] rd_word;
  always_comb begin
    rd_word = cfg_q & wr_mask;
    rd_word[BYTE_ORDER_BIT] = order_q;
    rd_word[BUS_ROLE_BIT] = role_q;
    rd_word[AREA0_MUXED_BIT] = type_q;
  end

  wire ack_d = req && addr_hit;
  wire err_d = req && !addr_hit;
  // data is zero outside an answered read, so stale words never leak
  wire [31:0] dat_d = (req && addr_hit && !wb_we_i) ? rd_word
    : 32'h0000_0000;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= ack_d;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wb_err_o <= 1'b0;
    end else begin
      wb_err_o <= err_d;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= dat_d;
    end
  end

  // ----------------------------------------------------------------
  // decoded controls
  // ----------------------------------------------------------------
  wire muxed_all = cfg_q[AREAS_MUX_BIT];
  wire [2:0] burst_code = cfg_q[AREA0_BURST_MSB:AREA0_BURST_LSB];
  logic [5:0] burst_len;
  always_comb begin
    case (burst_code)
      BURST_4: burst_len = 6'h04;
      BURST_8: burst_len = 6'h08;
      BURST_16: burst_len = 6'h10;
      BURST_32: burst_len = 6'h20;
      default: burst_len = 6'h00;
    endcase
  end

  wire little_endian_d = order_q;
  wire slave_mode_d = role_q;
  wire area0_muxed_d = type_q;
  // data pull-ups never fight a driver: off during access and bus release
  wire data_pullup_d = HAS_EXT_FEATURES && !cfg_q[DATA_PULLUP_BIT]
    && !bus_access_active && !bus_released;
  wire input_pullup_d = !cfg_q[INPUT_PULLUP_BIT];
  wire output_pullup_d = !cfg_q[OUTPUT_PULLUP_BIT];
  wire area1_bc_d = cfg_q[AREA1_BC_BIT] && !muxed_all;
  wire area4_bc_d = cfg_q[AREA4_BC_BIT] && !muxed_all;
  wire ext_accept_d = cfg_q[EXT_REQ_BIT] && !role_q;
  wire pshare_d = cfg_q[PSHARE_BIT] && !role_q;
  wire muxed_sel_d = muxed_all;
  wire drive_en_d = !bus_released
    && (!standby_mode || cfg_q[STANDBY_ADDR_BIT]);
  wire [5:0] burst_count_d = type_q ? 6'h00 : burst_len;
  wire burst_rom_d = !type_q && (burst_len != 6'h00);

  // each control leaves from its own flop, so the controller sees no glitch
  always_ff @(posedge clk) begin
    if (!nrst) begin
      little_endian <= 1'b0;
    end else begin
      little_endian <= little_endian_d;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      slave_mode <= 1'b0;
    end else begin
      slave_mode <= slave_mode_d;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      area0_muxed_type <= 1'b0;
    end else begin
      area0_muxed_type <= area0_muxed_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      data_pullup_en <= 1'b0;
    end else begin
      data_pullup_en <= data_pullup_d;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      input_pullup_en <= 1'b0;
    end else begin
      input_pullup_en <= input_pullup_d;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      output_pullup_en <= 1'b0;
    end else begin
      output_pullup_en <= output_pullup_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      area1_byte_ctrl <= 1'b0;
    end else begin
      area1_byte_ctrl <= area1_bc_d;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      area4_byte_ctrl <= 1'b0;
    end else begin
      area4_byte_ctrl <= area4_bc_d;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_request_accept <= 1'b0;
    end else begin
      ext_request_accept <= ext_accept_d;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      partial_share_mode <= 1'b0;
    end else begin
      partial_share_mode <= pshare_d;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      areas_muxed_select <= 1'b0;
    end else begin
      areas_muxed_select <= muxed_sel_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      addr_strobe_drive_en <= 1'b0;
    end else begin
      addr_strobe_drive_en <= drive_en_d;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      area0_burst_count <= 6'h00;
    end else begin
      area0_burst_count <= burst_count_d;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      area0_burst_rom <= 1'b0;
    end else begin
      area0_burst_rom <= burst_rom_d;
    end
  end
endmodule
`default_nettype wire

//--- rtl/bus_cfg_pkg.sv
// Purpose: constants for the bus area configuration register block
// Assumes: classic Wishbone slave, 32-bit data, one aligned word
// Notes: all layout and reset figures live here
// How it works
// - 32-bit read/write register, clears at power-on
// - manual reset and standby keep contents
// - bit 31 byte order from pin
// - bit 30 master/slave, pin inverted
// - bit 29 area 0 type, pin inverted
// - reserved bits read zero, written zero
// - bit 26 data pull-ups, off in access/release
// - bit 25 control input pull-ups
// - bit 24 output pull-ups while floating
// - bit 21 area 1 byte control, muxed wins
// - bit 20 area 4 byte control, muxed wins
// - bit 19 accept external requests, master only
// - bit 18 partial sharing, master startup only
// - bit 17 areas 1-6 muxed interface select
// - bit 15 standby drive, float when released
// - bits 13-11 area 0 burst length code
package bus_cfg_pkg;
  localparam logic [31:0] BUS_CONTROL_ONE_ADDR = 32'h0000_0000;
  localparam logic [31:0] BUS_CONTROL_ONE_RESET = 32'h0000_0000;
  localparam int BYTE_ORDER_BIT = 31;
  localparam int BUS_ROLE_BIT = 30;
  localparam int AREA0_MUXED_BIT = 29;
  localparam int DATA_PULLUP_BIT = 26;
  localparam int INPUT_PULLUP_BIT = 25;
  localparam int OUTPUT_PULLUP_BIT = 24;
  localparam int AREA1_BC_BIT = 21;
  localparam int AREA4_BC_BIT = 20;
  localparam int EXT_REQ_BIT = 19;
  localparam int PSHARE_BIT = 18;
  localparam int AREAS_MUX_BIT = 17;
  localparam int DMA_BURST_BIT = 16;
  localparam int STANDBY_ADDR_BIT = 15;
  localparam int STANDBY_STROBE_BIT = 14;
  localparam int AREA0_BURST_LSB = 11;
  localparam int AREA0_BURST_MSB = 13;
  // writable mask: bits 26..24, 21..17, 15..2, 0 (26 optional feature)
  localparam logic [31:0] WRITE_MASK_BASE = 32'h073E_FFFD;
  localparam logic [31:0] DMA_BURST_MASK = 32'h0001_0000;
  localparam logic [31:0] DATA_PULLUP_MASK = 32'h0400_0000;
  localparam logic [2:0] BURST_SRAM = 3'h0;
  localparam logic [2:0] BURST_4 = 3'h1;
  localparam logic [2:0] BURST_8 = 3'h2;
  localparam logic [2:0] BURST_16 = 3'h3;
  localparam logic [2:0] BURST_32 = 3'h4;
endpackage

//--- rtl/bit_sync.sv
// Purpose: two-flop synchroniser for one pin
// Assumes: pin is asynchronous to clk
// Notes: first flop feeds only the second
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  output logic sync
);
  logic meta_q;
  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_q <= 1'b0;
      sync <= 1'b0;
    end else begin
      meta_q <= pin;
      sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

//--- tb/bus_area_config_register_properties.sv
// Purpose: port-level checks of the bus configuration register
// Assumes: nrst is the power-on reset, classic Wishbone master
// Notes: bound into the design, watches its ports (inputs and outputs) only
`timescale 1ns/1ps
`default_nettype none
module bus_cfg_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [31:0] wb_adr_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic bus_access_active,
  input wire logic bus_released,
  input wire logic slave_mode,
  input wire logic data_pullup_en,
  input wire logic area1_byte_ctrl,
  input wire logic areas_muxed_select,
  input wire logic ext_request_accept,
  input wire logic partial_share_mode,
  input wire logic addr_strobe_drive_en
);
  logic [2:0] age_q;
  wire taken = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire mapped = wb_adr_i[31:2] == 30'h0;
  // pins settle and get captured a few edges after release; wait that out
  always_ff @(posedge clk) begin
    age_q <= !nrst ? 3'h0 : age_q + {2'h0, age_q != 3'h7};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_map_ack: assert property (taken && mapped |=> wb_ack_o && !wb_err_o)
    else $error("no ack");
  a_unmap_err: assert property (taken && !mapped |=> wb_err_o && !wb_ack_o)
    else $error("no err");
  a_rsvd_zero: assert property
    (wb_ack_o |-> (wb_dat_o & 32'h18C1_0002) == 32'h0) else $error("rsvd");
  a_slave_gate: assert property
    (ext_request_accept || partial_share_mode |-> !slave_mode)
    else $error("slave gate");
  a_mux_wins: assert property (area1_byte_ctrl |-> !areas_muxed_select)
    else $error("mux prio");
  a_pull_off: assert property
    (bus_access_active || bus_released |=> !data_pullup_en)
    else $error("pullup");
  a_rel_float: assert property (bus_released |=> !addr_strobe_drive_en)
    else $error("drive");
  a_pins_hold: assert property (age_q == 3'h7 |-> $stable(slave_mode))
    else $error("pin moved");
  c_ack: cover property (wb_ack_o);
  c_err: cover property (wb_err_o);
  c_accept: cover property (ext_request_accept);
endmodule
bind bus_area_config_register bus_cfg_properties u_props (
  .clk(clk), .nrst(nrst), .wb_adr_i(wb_adr_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .bus_access_active(bus_access_active),
  .bus_released(bus_released), .slave_mode(slave_mode),
  .data_pullup_en(data_pullup_en), .area1_byte_ctrl(area1_byte_ctrl),
  .areas_muxed_select(areas_muxed_select),
  .ext_request_accept(ext_request_accept),
  .partial_share_mode(partial_share_mode),
  .addr_strobe_drive_en(addr_strobe_drive_en)
);
`default_nettype wire

//--- tb/bus_area_config_register_tb.sv
// Purpose: directed Wishbone test of the bus configuration register
// Assumes: register at offset 0x0, optional feature bits present
// Notes: one-bit outputs gathered in o for compact compares
`timescale 1ns/1ps
`default_nettype none
module bus_area_config_register_tb;
  logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, er;
  logic acc = 1'b0, rel = 1'b0, sby = 1'b0, p_end = 1'b0, p_role = 1'b0;
  logic p_a0 = 1'b0, ack, err;
  logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, rd, r;
  logic [12:0] o;
  logic [5:0] cnt;
  logic [3:0] sel = 4'hF;
  logic [3:0] lanes = 4'hF;
  int err_total = 0, checked = 0;
  initial forever #2.5 clk = ~clk;
  bus_area_config_register dut (
    .clk(clk), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .byte_order_pin(p_end),
    .bus_role_pin(p_role), .area0_type_pin(p_a0), .bus_access_active(acc),
    .bus_released(rel), .standby_mode(sby), .little_endian(o[0]),
    .slave_mode(o[1]), .area0_muxed_type(o[2]), .data_pullup_en(o[3]),
    .input_pullup_en(o[4]), .output_pullup_en(o[5]), .area1_byte_ctrl(o[6]),
    .area4_byte_ctrl(o[7]), .ext_request_accept(o[8]),
    .partial_share_mode(o[9]), .areas_muxed_select(o[10]),
    .addr_strobe_drive_en(o[11]), .area0_burst_count(cnt),
    .area0_burst_rom(o[12])
  );
  function automatic logic [5:0] bc(input logic [31:0] v);
    bc = (!v[29] && v[13:11] >= 3'h1 && v[13:11] <= 3'h4) ?
      6'h2 << v[13:11] : 6'h0;
  endfunction
  function automatic logic [12:0] eo(input logic [31:0] v);
    eo = {bc(v) != 6'h0, !rel & (!sby | v[15]), v[17], v[18] & !v[30],
      v[19] & !v[30], v[20] & !v[17], v[21] & !v[17], !v[24], !v[25],
      !v[26] & !acc & !rel, v[29], v[30], v[31]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // the master holds the request until the edge that samples ack or err
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'h3, w, a, d, lanes};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 40);
    if (n == 40) begin
      err_total++;
      finish_test();
    end
    rd = rdat;
    er = err;
    {cyc, stb} <= 2'h0;
  endtask
  task automatic rst(input logic [2:0] pins);
    @(posedge clk);
    nrst <= 1'b0;
    {p_end, p_role, p_a0} <= pins;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic verify();
    xfer(1'b0, 32'h0, 32'h0);
    chk(rd, r);
    chk({19'h0, o}, {19'h0, eo(r)});
    chk({26'h0, cnt}, {26'h0, bc(r)});
  endtask
  initial begin
    rst(3'h5);
    r = 32'hC000_0000;
    verify();
    {p_end, p_role, p_a0} <= 3'h2;
    verify();
    xfer(1'b1, 32'h0, 32'hFFFF_FFFF);
    r = 32'hC73E_FFFD;
    verify();
    lanes = 4'h2;
    xfer(1'b1, 32'h0, 32'h0);
    lanes = 4'hF;
    r = 32'hC73E_00FD;
    verify();
    xfer(1'b1, 32'h4, 32'h0);
    chk({31'h0, er}, 32'h1);
    verify();
    for (int c = 0; c < 8; c++) begin
      {acc, rel, sby} <= 3'(c);
      r = (c[0] ? 32'h0230_8000 : 32'h0) | (32'(c) << 11);
      xfer(1'b1, 32'h0, r);
      r = r | 32'hC000_0000;
      verify();
    end
    {acc, rel, sby} <= 3'h0;
    rst(3'h2);
    r = 32'h2000_0000;
    verify();
    xfer(1'b1, 32'h0, 32'hFFFF_FFFF);
    r = 32'h273E_FFFD;
    verify();
    finish_test();
  end
endmodule
`default_nettype wire
